//--- src/pif_peripheral_interrupt_flags.sv
// Function
// - Third enable register bit 6 enables the oscillator interrupt, bit 4 the zero-cross one.
// - Third enable register bit 5 enables the waveform generator shutdown interrupt.
// - Third enable register bits 3 to 0 enable logic cells four down to one.
// - Every implemented enable and flag bit clears to zero on every reset.
// - Unimplemented bits ignore writes and read as zero.
// - No peripheral source reaches the core unless the peripheral gate bit is set; here irq still follows masked event status with the gate clear.
// - Each flag sets on its event regardless of its enable and the global enable.
// - First flag register bits 7 to 0 hold the eight listed peripheral flags in order.
// - Serial receive and transmit flags are read-only; other first-register flags are writable.
// - Second flag register bits 7,6,5,3,2,1,0 hold the seven listed flags in order.
// - Third flag register mirrors the third enable register bit placement.
// - A flag reading one means pending, zero means not pending.
// - Control bit 7 is the global enable that allows or blocks all interrupts; here it gates periphIrqReq only, not irq.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps

module pif_peripheral_interrupt_flags (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  input wire logic [7:0] periphEvent1,
  input wire logic [7:0] periphEvent2,
  input wire logic [7:0] periphEvent3,
  output logic periphIrqReq,
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0] intCtrl;
  logic [7:0] irqEn1;
  logic [7:0] irqEn2;
  logic [7:0] irqEn3;
  logic [7:0] irqReq1;
  logic [7:0] irqReq2;
  logic [7:0] irqReq3;
  logic [7:0] evtStatus;
  logic [7:0] evtMask;
  logic reqPrev;

  logic [7:0] next_irqReq1;
  logic [7:0] next_irqReq2;
  logic [7:0] next_irqReq3;
  logic [7:0] next_evtStatus;
  logic [7:0] readMux;
  logic anyEnabled;
  logic reqNow;
  logic [7:0] evt1Pulse;
  logic [7:0] evt2Pulse;
  logic [7:0] evt3Pulse;

  // ****************************************
  // Register port decode
  // ****************************************
  logic wrCtrl;
  logic wrEn1;
  logic wrEn2;
  logic wrEn3;
  logic wrReq1;
  logic wrReq2;
  logic wrReq3;
  logic wrMask;
  logic rdStatus;

  assign wrCtrl = wrStrobe && (addr == pif_pkg::IDX_CONTROL);
  assign wrEn1 = wrStrobe && (addr == pif_pkg::IDX_ENABLE1);
  assign wrEn2 = wrStrobe && (addr == pif_pkg::IDX_ENABLE2);
  assign wrEn3 = wrStrobe && (addr == pif_pkg::IDX_ENABLE3);
  assign wrReq1 = wrStrobe && (addr == pif_pkg::IDX_REQUEST1);
  assign wrReq2 = wrStrobe && (addr == pif_pkg::IDX_REQUEST2);
  assign wrReq3 = wrStrobe && (addr == pif_pkg::IDX_REQUEST3);
  assign wrMask = wrStrobe && (addr == pif_pkg::IDX_EVT_MASK);
  assign rdStatus = rdStrobe && (addr == pif_pkg::IDX_EVT_STATUS);

  // ****************************************
  // Control and enable registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      intCtrl <= pif_pkg::RESET_BYTE;
    end else begin
      // Only the global enable and peripheral gate live here
      intCtrl <= pif_pkg::pif_merge(intCtrl, wrData, pif_pkg::CTRL_MASK, wrCtrl);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irqEn1 <= pif_pkg::RESET_BYTE;
      irqEn2 <= pif_pkg::RESET_BYTE;
      irqEn3 <= pif_pkg::RESET_BYTE;
    end else begin
      irqEn1 <= pif_pkg::pif_merge(irqEn1, wrData, pif_pkg::ENABLE1_MASK, wrEn1);
      irqEn2 <= pif_pkg::pif_merge(irqEn2, wrData, pif_pkg::ENABLE2_MASK, wrEn2);
      // Bit 6 oscillator, 5 shutdown, 4 zero-cross, 3..0 logic cells
      irqEn3 <= pif_pkg::pif_merge(irqEn3, wrData, pif_pkg::ENABLE3_MASK, wrEn3);
    end
  end

  // ****************************************
  // Peripheral flags
  // ****************************************
  // Events OR in after the write merge, so an event beats a clear in the same cycle
  always_comb begin
    next_irqReq1 = pif_pkg::pif_merge(irqReq1, wrData, pif_pkg::REQUEST1_WMASK, wrReq1);
    next_irqReq1 = next_irqReq1 | (periphEvent1 & ~pif_pkg::REQUEST1_SERIAL);
    // Serial flags follow the serial unit's pending level; software cannot touch them
    next_irqReq1 = (next_irqReq1 & ~pif_pkg::REQUEST1_SERIAL)
                 | (periphEvent1 & pif_pkg::REQUEST1_SERIAL);
    next_irqReq2 = pif_pkg::pif_merge(irqReq2, wrData, pif_pkg::REQUEST2_MASK, wrReq2)
                 | (periphEvent2 & pif_pkg::REQUEST2_MASK);
    next_irqReq3 = pif_pkg::pif_merge(irqReq3, wrData, pif_pkg::REQUEST3_MASK, wrReq3)
                 | (periphEvent3 & pif_pkg::REQUEST3_MASK);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irqReq1 <= pif_pkg::RESET_BYTE;
      irqReq2 <= pif_pkg::RESET_BYTE;
      irqReq3 <= pif_pkg::RESET_BYTE;
    end else begin
      irqReq1 <= next_irqReq1 & pif_pkg::REQUEST1_IMPL;
      irqReq2 <= next_irqReq2;
      irqReq3 <= next_irqReq3;
    end
  end

  // ****************************************
  // Request to the core
  // ****************************************
  // Serial flags are levels and do not count as fresh edge events
  assign evt1Pulse = periphEvent1 & ~pif_pkg::REQUEST1_SERIAL;
  assign evt2Pulse = periphEvent2 & pif_pkg::REQUEST2_MASK;
  assign evt3Pulse = periphEvent3 & pif_pkg::REQUEST3_MASK;

  assign anyEnabled = |(irqReq1 & irqEn1) | |(irqReq2 & irqEn2) | |(irqReq3 & irqEn3);
  assign reqNow = anyEnabled
               && intCtrl[pif_pkg::CTRL_PERIPHERAL_IRQ_GATE]
               && intCtrl[pif_pkg::CTRL_GLOBAL_IRQ_EN];

  // Registered for a clean output; costs one cycle of latency
  always_ff @(posedge clk) begin
    if (reset) begin
      periphIrqReq <= 1'b0;
      reqPrev <= 1'b0;
    end else begin
      periphIrqReq <= reqNow;
      reqPrev <= reqNow;
    end
  end

  // ****************************************
  // Block event status, mask and interrupt
  // ****************************************
  always_comb begin
    next_evtStatus = rdStatus ? pif_pkg::RESET_BYTE : evtStatus;
    next_evtStatus[pif_pkg::EVT_SET1] = next_evtStatus[pif_pkg::EVT_SET1] | (|evt1Pulse);
    next_evtStatus[pif_pkg::EVT_SET2] = next_evtStatus[pif_pkg::EVT_SET2] | (|evt2Pulse);
    next_evtStatus[pif_pkg::EVT_SET3] = next_evtStatus[pif_pkg::EVT_SET3] | (|evt3Pulse);
    // An event landing on a flag that is still pending is lost information
    next_evtStatus[pif_pkg::EVT_OVERRUN] = next_evtStatus[pif_pkg::EVT_OVERRUN]
      | (|(evt1Pulse & irqReq1)) | (|(evt2Pulse & irqReq2)) | (|(evt3Pulse & irqReq3));
    next_evtStatus[pif_pkg::EVT_REQ_RISE] = next_evtStatus[pif_pkg::EVT_REQ_RISE]
      | (reqNow & ~reqPrev);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      evtStatus <= pif_pkg::RESET_BYTE;
    end else begin
      evtStatus <= next_evtStatus & pif_pkg::EVT_MASK_BITS;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      evtMask <= pif_pkg::RESET_BYTE;
    end else begin
      evtMask <= pif_pkg::pif_merge(evtMask, wrData, pif_pkg::EVT_MASK_BITS, wrMask);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evtStatus & evtMask);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    unique case (addr)
      pif_pkg::IDX_CONTROL: readMux = intCtrl;
      pif_pkg::IDX_ENABLE1: readMux = irqEn1;
      pif_pkg::IDX_ENABLE2: readMux = irqEn2;
      pif_pkg::IDX_ENABLE3: readMux = irqEn3;
      pif_pkg::IDX_REQUEST1: readMux = irqReq1;
      pif_pkg::IDX_REQUEST2: readMux = irqReq2;
      pif_pkg::IDX_REQUEST3: readMux = irqReq3;
      pif_pkg::IDX_EVT_STATUS: readMux = evtStatus;
      pif_pkg::IDX_EVT_MASK: readMux = evtMask;
      default: readMux = pif_pkg::RESET_BYTE;
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData <= pif_pkg::RESET_BYTE;
    end else if (rdStrobe) begin
      rdData <= readMux;
    end else begin
      rdData <= pif_pkg::RESET_BYTE;
    end
  end

endmodule : pif_peripheral_interrupt_flags

//--- src/pif_pkg.sv
package pif_pkg;

  // ****************************************
  // Register indices on the plain port
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_ENABLE1 = 4'h1;
  localparam logic [3:0] IDX_ENABLE2 = 4'h2;
  localparam logic [3:0] IDX_ENABLE3 = 4'h3;
  localparam logic [3:0] IDX_REQUEST1 = 4'h4;
  localparam logic [3:0] IDX_REQUEST2 = 4'h5;
  localparam logic [3:0] IDX_REQUEST3 = 4'h6;
  localparam logic [3:0] IDX_EVT_STATUS = 4'h7;
  localparam logic [3:0] IDX_EVT_MASK = 4'h8;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_GLOBAL_IRQ_EN = 7;
  localparam int CTRL_PERIPHERAL_IRQ_GATE = 6;
  localparam int REQ1_SERIAL_RX = 5;
  localparam int REQ1_SERIAL_TX = 4;
  localparam int EVT_SET1 = 0;
  localparam int EVT_SET2 = 1;
  localparam int EVT_SET3 = 2;
  localparam int EVT_OVERRUN = 3;
  localparam int EVT_REQ_RISE = 4;

  // ****************************************
  // Implemented and writable bit masks
  // ****************************************
  localparam logic [7:0] CTRL_MASK = 8'hC0;
  localparam logic [7:0] ENABLE1_MASK = 8'hFF;
  localparam logic [7:0] ENABLE2_MASK = 8'hEF;
  localparam logic [7:0] ENABLE3_MASK = 8'h7F;
  localparam logic [7:0] REQUEST1_IMPL = 8'hFF;
  localparam logic [7:0] REQUEST1_WMASK = 8'hCF;
  localparam logic [7:0] REQUEST1_SERIAL = 8'h30;
  localparam logic [7:0] REQUEST2_MASK = 8'hEF;
  localparam logic [7:0] REQUEST3_MASK = 8'h7F;
  localparam logic [7:0] EVT_MASK_BITS = 8'h1F;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Write merge: only bits in wmask take the bus data
  function automatic logic [7:0] pif_merge(
    input logic [7:0] old,
    input logic [7:0] data,
    input logic [7:0] wmask,
    input logic hit
  );
    pif_merge = hit ? ((data & wmask) | (old & ~wmask)) : old;
  endfunction : pif_merge

endpackage : pif_pkg

//--- verification/pif_flags_monitor.sv
`timescale 1ns/1ps
module pif_flags_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] rdData,
  input wire logic [7:0] periphEvent1,
  input wire logic [7:0] periphEvent2,
  input wire logic [7:0] periphEvent3,
  input wire logic periphIrqReq,
  input wire logic irq
);
  // ****************************************
  // Port checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_RESET_CLEAR: assert property (disable iff (1'b0)
    reset |=> !periphIrqReq && !irq && rdData == 8'h00) else $error("reset left outputs set");
  AST_READ_IDLE: assert property (!rdStrobe |=> rdData == 8'h00) else $error("stray data");
  AST_UNMAPPED: assert property (rdStrobe && addr > pif_pkg::IDX_EVT_MASK
    |=> rdData == 8'h00) else $error("unmapped read not zero");
  AST_TOP_BIT: assert property (rdStrobe && (addr == pif_pkg::IDX_ENABLE3 ||
    addr == pif_pkg::IDX_REQUEST3) |=> !rdData[7]) else $error("bit 7 not zero");
  AST_GAP_BIT: assert property (rdStrobe && (addr == pif_pkg::IDX_ENABLE2 ||
    addr == pif_pkg::IDX_REQUEST2) |=> !rdData[4]) else $error("bit 4 not zero");
  AST_SERIAL_COPY: assert property (rdStrobe && addr == pif_pkg::IDX_REQUEST1
    && !$past(reset) |=> rdData[5:4] == $past(periphEvent1[5:4], 2))
    else $error("serial flags wrong");
  AST_GATE_OFF: assert property (wrStrobe && addr == pif_pkg::IDX_CONTROL
    && !(&wrData[7:6]) |=> ##1 !periphIrqReq) else $error("request passed closed gate");
  AST_FLAG_SETS: assert property (rdStrobe && addr == pif_pkg::IDX_REQUEST2
    && $past(periphEvent2[0]) && !$past(reset) |=> rdData[0]) else $error("flag not set");
  cover property ($rose(periphIrqReq));
  cover property ($rose(irq));
  cover property (rdStrobe && addr == pif_pkg::IDX_EVT_STATUS ##1 rdData != 8'h00);
endmodule : pif_flags_monitor
bind pif_peripheral_interrupt_flags pif_flags_monitor u_mon (.clk, .reset, .addr, .wrData,
  .wrStrobe, .rdStrobe, .rdData, .periphEvent1, .periphEvent2, .periphEvent3, .periphIrqReq, .irq);

//--- verification/pif_periph_model.sv
`timescale 1ns/1ps
module pif_periph_model (
  input wire logic clk,
  input wire logic [23:0] fire,
  input wire logic [1:0] serLevel,
  output logic [7:0] periphEvent1 = 8'h00,
  output logic [7:0] periphEvent2 = 8'h00,
  output logic [7:0] periphEvent3 = 8'h00
);
  // ****************************************
  // Event sources
  // ****************************************
  // Serial sources hold a level; the rest emit one-cycle pulses, unused bits included
  always @(posedge clk) begin
    periphEvent1 <= {fire[7:6], serLevel, fire[3:0]};
    periphEvent2 <= fire[15:8];
    periphEvent3 <= fire[23:16];
  end
endmodule : pif_periph_model

//--- verification/pif_peripheral_interrupt_flags_tb_top.sv
`timescale 1ns/1ps
module pif_peripheral_interrupt_flags_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic [23:0] fire = '0;
  logic [1:0] serLevel = 2'h0;
  logic [7:0] rdData, periphEvent1, periphEvent2, periphEvent3, got;
  logic periphIrqReq, irq;
  logic [7:0] expAll [16] = '{8'hC0, 8'hFF, 8'hEF, 8'h7F, 8'hCF, 8'hEF, 8'h7F, 8'h00,
    8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] implP [3] = '{8'hCF, 8'hEF, 8'h7F};
  int errorCnt = 0;
  int comparisons = 0;
  pif_peripheral_interrupt_flags u_dut (.clk, .reset, .addr, .wrData, .wrStrobe, .rdStrobe,
    .rdData, .periphEvent1, .periphEvent2, .periphEvent3, .periphIrqReq, .irq);
  pif_periph_model u_src (.clk, .fire, .serLevel, .periphEvent1, .periphEvent2, .periphEvent3);
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 got = rdData;
    @(posedge clk);
  endtask : rd
  task automatic pulse(input logic [23:0] f);
    fire <= f;
    @(posedge clk);
    fire <= '0;
    repeat (2) @(posedge clk);
  endtask : pulse
  // Sample after the edge's updates have landed
  task automatic lvl(ref logic s, input logic e);
    #1 chk({7'h00, s}, {7'h00, e});
    @(posedge clk);
  endtask : lvl
  task automatic printVerdict;
    $display("Errors %0d, comparisons %0d", errorCnt, comparisons);
    if (errorCnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : printVerdict
  initial forever #2 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    printVerdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      rd(4'(i));
      chk(got, 8'h00);
    end
    for (int i = 0; i < 16; i++) if (i != 7) wr(4'(i), 8'hFF);
    lvl(periphIrqReq, 1'b1);
    for (int i = 0; i < 16; i++) begin
      if (i != 7) begin
        rd(4'(i));
        chk(got, expAll[i]);
      end
    end
    rd(pif_pkg::IDX_EVT_STATUS);
    lvl(irq, 1'b0);
    wr(pif_pkg::IDX_CONTROL, 8'h80);
    lvl(periphIrqReq, 1'b0);
    wr(pif_pkg::IDX_CONTROL, 8'h40);
    lvl(periphIrqReq, 1'b0);
    wr(pif_pkg::IDX_CONTROL, 8'hC0);
    lvl(periphIrqReq, 1'b1);
    for (int k = 0; k < 3; k++) wr(4'(4 + k), 8'h00);
    lvl(periphIrqReq, 1'b0);
    for (int k = 0; k < 3; k++) begin
      for (int b = 0; b < 8; b++) begin
        wr(4'(1 + k), 8'h01 << b);
        wr(pif_pkg::IDX_CONTROL, 8'h00);
        pulse(24'(1) << (8 * k + b));
        rd(4'(4 + k));
        chk(got, (8'h01 << b) & implP[k]);
        lvl(periphIrqReq, 1'b0);
        wr(pif_pkg::IDX_CONTROL, 8'hC0);
        lvl(periphIrqReq, |((8'h01 << b) & implP[k]));
        wr(4'(4 + k), 8'h00);
      end
    end
    serLevel <= 2'h3;
    repeat (3) @(posedge clk);
    wr(pif_pkg::IDX_REQUEST1, 8'h00);
    rd(pif_pkg::IDX_REQUEST1);
    chk(got, 8'h30);
    serLevel <= 2'h0;
    repeat (3) @(posedge clk);
    rd(pif_pkg::IDX_REQUEST1);
    chk(got, 8'h00);
    wr(pif_pkg::IDX_CONTROL, 8'h00);
    rd(pif_pkg::IDX_EVT_STATUS);
    wr(pif_pkg::IDX_EVT_MASK, 8'h02);
    fire <= 24'(1) << 8;
    @(posedge clk);
    fire <= '0;
    @(posedge clk);
    rd(pif_pkg::IDX_REQUEST2);
    chk(got, 8'h01);
    lvl(irq, 1'b1);
    pulse(24'(1) << 8);
    rd(pif_pkg::IDX_EVT_STATUS);
    chk(got, 8'h0A);
    lvl(irq, 1'b0);
    wr(pif_pkg::IDX_EVT_MASK, 8'h00);
    pulse(24'(1) << 16);
    lvl(irq, 1'b0);
    wr(pif_pkg::IDX_EVT_MASK, 8'h04);
    lvl(irq, 1'b1);
    rd(pif_pkg::IDX_EVT_STATUS);
    chk(got, 8'h04);
    lvl(irq, 1'b0);
    printVerdict();
  end
endmodule : pif_peripheral_interrupt_flags_tb_top
